// [pkg/tpc_defines.svh]
// Purpose: offsets, fields, reset values and counts for the timer pwm compare block
// Assumes: ahb-lite word registers, byte addresses
// Notes: included by bare name
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH
`define TPC_OFF_CTRL8     12'h000
`define TPC_OFF_CMPA8     12'h004
`define TPC_OFF_CMPB8     12'h008
`define TPC_OFF_COUNT8    12'h00c
`define TPC_OFF_CTRLA16   12'h010
`define TPC_OFF_CTRLB16   12'h014
`define TPC_OFF_CMPA16    12'h018
`define TPC_OFF_CMPB16    12'h01c
`define TPC_OFF_COUNT16   12'h020
`define TPC_OFF_DIR       12'h024
`define TPC_OFF_STATUS    12'h028
`define TPC_OFF_MASK      12'h02c
`define TPC_OFF_PINS      12'h030
`define TPC_CTRLA16_RST   8'h00
`define TPC_CTRLA16_WMASK 8'hf3
`define TPC_TOP8_FULL     8'hff
`define TPC_TOP16_FULL    16'hffff
`define TPC_ST_OVF8       0
`define TPC_ST_OVF16      1
`define TPC_ST_MATCHA8    2
`define TPC_ST_MATCHB8    3
`define TPC_ST_MATCHA16   4
`define TPC_ST_MATCHB16   5
`define TPC_ST_W          6
`define TPC_PS_DIV8       11'd8
`define TPC_PS_DIV64      11'd64
`define TPC_PS_DIV256     11'd256
`define TPC_PS_DIV1024    11'd1024
`endif

// [pkg/tpc_pkg.sv]
// Purpose: types for the timer pwm compare block
// Assumes: nothing
// Notes: constants live in tpc_defines.svh
package tpc_pkg;
  typedef enum logic [1:0] {
    TPC_IDLE = 2'b00,
    TPC_DATA = 2'b01,
    TPC_DONE = 2'b11
  } tpc_bus_t;
  typedef enum logic [1:0] {
    TPC_PS_OFF = 2'b00,
    TPC_PS_RUN = 2'b01
  } tpc_ps_t;
endpackage

// [hdl/tpc_top.sv]
// Purpose: 8-bit dual-slope pwm timer and 16-bit compare output control
// Assumes: single hclk domain, ahb-lite slave, okay-only answers
// Notes: zero wait states
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "tpc_defines.svh"
// Notes on behaviour
// - wave mode 1 or 5 makes the 8-bit counter run up then down
// - dual-slope top is 0xff for mode 1, compare a for mode 5
// - non-inverting clears on upcount match, sets on downcount; inverting opposite
// - out mode two is non-inverted pwm, three is inverted pwm
// - counter reverses at top and at bottom without holding either value an extra timer tick
// - overflow flag sets each time dual-slope counter reaches bottom
// - out mode a low bit with mode top bit toggles output a
// - compare output reaches pin only when its direction bit is output
// - mode 1 pwm frequency is clock over prescale times 510; prescales 1..1024
// - fast pwm mode 7 toggles output a, compare register double buffered
// - nonzero 16-bit out mode overrides port, except 01 on a in odd non-fast modes and 01 on b in modes 14 or 15; direction bit still needed
// - non-pwm modes: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast pwm: 10 clear on match set at top; 11 opposite
// - fast pwm mode 01 toggles a only in modes 14 or 15, else off
// - fast pwm compare equal to top ignores match, top action stays
// - control a: a mode 7:6, b mode 5:4, 3:2 zero, wave bits 1:0
module tpc_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  output logic             pin_a8_o,
  output logic             pin_a8_oe,
  output logic             pin_b8_o,
  output logic             pin_b8_oe,
  output logic             pin_a16_o,
  output logic             pin_a16_oe,
  output logic             pin_b16_o,
  output logic             pin_b16_oe
);
  // bus address phase capture
  logic        wr_q;
  logic        rd_q;
  logic [11:0] addr_q;
  tpc_pkg::tpc_bus_t bus_q;
  // 8-bit timer: ctrl8 = [7:6] out mode a, [5:4] out mode b, [2:0] wave mode, [10:8] prescale
  logic [1:0]  out_mode_a8_q;
  logic [1:0]  out_mode_b8_q;
  logic [2:0]  wave_mode_sel_q;
  logic [2:0]  clk_sel8_q;
  logic [7:0]  compare_value_a_q;
  logic [7:0]  compare_value_b_q;
  logic [7:0]  cmpa8_buf_q;
  logic [7:0]  cmpb8_buf_q;
  logic [7:0]  timer8_count_q;
  logic        down8_q;
  logic        compare_out_a8_q;
  logic        compare_out_b8_q;
  // 16-bit timer
  logic [7:0]  timer16_control_a_q;
  logic [2:0]  ctrlb16_q;
  logic [15:0] compare_value_a16_q;
  logic [15:0] compare_value_b16_q;
  logic [15:0] cmpa16_buf_q;
  logic [15:0] cmpb16_buf_q;
  logic [15:0] count16_q;
  logic        compare_out_a16_q;
  logic        compare_out_b16_q;
  logic [3:0]  dir_q;
  logic [`TPC_ST_W-1:0] status_q;
  logic [`TPC_ST_W-1:0] mask_q;
  logic [10:0] ps_cnt_q;
  tpc_pkg::tpc_ps_t ps_q;
  logic        tick;
  logic [10:0] ps_div;
  logic [31:0] rdata_d;
  logic [`TPC_ST_W-1:0] ev;

  always_comb begin
    case (clk_sel8_q)
      3'd2:    ps_div = `TPC_PS_DIV8;
      3'd3:    ps_div = `TPC_PS_DIV64;
      3'd4:    ps_div = `TPC_PS_DIV256;
      3'd5:    ps_div = `TPC_PS_DIV1024;
      default: ps_div = 11'd1;
    endcase
  end

  // prescaler: one-cycle timer tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ps_cnt_q <= 11'h000;
      ps_q     <= tpc_pkg::TPC_PS_OFF;
    end else if (clk_sel8_q == 3'd0) begin
      ps_cnt_q <= 11'h000;
      ps_q     <= tpc_pkg::TPC_PS_OFF;
    end else begin
      ps_q <= tpc_pkg::TPC_PS_RUN;
      if (ps_cnt_q >= ps_div - 11'd1)
        ps_cnt_q <= 11'h000;
      else
        ps_cnt_q <= ps_cnt_q + 11'd1;
    end
  end
  assign tick = (ps_q == tpc_pkg::TPC_PS_RUN) && (ps_cnt_q == 11'h000);

  // 8-bit timer decode
  logic       dual8;
  logic       fast8;
  logic [7:0] top8;
  logic       at_top8;
  logic       ma8;
  logic       mb8;
  assign dual8   = (wave_mode_sel_q == 3'd1) || (wave_mode_sel_q == 3'd5);
  assign fast8   = (wave_mode_sel_q == 3'd3) || (wave_mode_sel_q == 3'd7);
  assign top8    = wave_mode_sel_q[2] ? compare_value_a_q : `TPC_TOP8_FULL;
  assign at_top8 = (timer8_count_q == top8);
  assign ma8     = (timer8_count_q == compare_value_a_q);
  assign mb8     = (timer8_count_q == compare_value_b_q);

  // 8-bit counter, direction and compare buffers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer8_count_q    <= 8'h00;
      down8_q           <= 1'b0;
      compare_value_a_q <= 8'h00;
      compare_value_b_q <= 8'h00;
    end else if (tick) begin
      if (dual8) begin
        if (!down8_q && at_top8) begin
          down8_q        <= 1'b1;
          timer8_count_q <= timer8_count_q - 8'd1;
        end else if (down8_q && timer8_count_q == 8'h00) begin
          down8_q        <= 1'b0;
          timer8_count_q <= 8'h01;
        end else begin
          timer8_count_q <= down8_q ? timer8_count_q - 8'd1 : timer8_count_q + 8'd1;
        end
        if (at_top8 && !down8_q) begin
          compare_value_a_q <= cmpa8_buf_q;
          compare_value_b_q <= cmpb8_buf_q;
        end
      end else begin
        down8_q <= 1'b0;
        if (at_top8) begin
          timer8_count_q    <= 8'h00;
          compare_value_a_q <= cmpa8_buf_q;
          compare_value_b_q <= cmpb8_buf_q;
        end else begin
          timer8_count_q <= timer8_count_q + 8'd1;
        end
      end
    end
  end

  // 8-bit compare outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_out_a8_q <= 1'b0;
      compare_out_b8_q <= 1'b0;
    end else if (tick) begin
      if (dual8) begin
        if (ma8 && out_mode_a8_q[1])
          compare_out_a8_q <= down8_q ^ out_mode_a8_q[0];
        else if (ma8 && out_mode_a8_q == 2'b01 && wave_mode_sel_q[2])
          compare_out_a8_q <= ~compare_out_a8_q;
        if (mb8 && out_mode_b8_q[1])
          compare_out_b8_q <= down8_q ^ out_mode_b8_q[0];
      end else if (fast8) begin
        if (ma8 && out_mode_a8_q == 2'b01 && wave_mode_sel_q[2])
          compare_out_a8_q <= ~compare_out_a8_q;
      end else begin
        if (ma8 && out_mode_a8_q == 2'b01)
          compare_out_a8_q <= ~compare_out_a8_q;
        if (mb8 && out_mode_b8_q == 2'b01)
          compare_out_b8_q <= ~compare_out_b8_q;
      end
    end
  end

  // 16-bit timer decode
  logic [3:0]  wave_mode16;
  logic [1:0]  out_mode_a16;
  logic [1:0]  out_mode_b16;
  logic        fast16;
  logic [15:0] top16;
  logic        at_top16;
  logic        ma16;
  logic        mb16;
  assign out_mode_a16 = timer16_control_a_q[7:6];
  assign out_mode_b16 = timer16_control_a_q[5:4];
  assign wave_mode16  = {ctrlb16_q[1:0], timer16_control_a_q[1:0]};
  assign fast16       = (wave_mode16 == 4'd14) || (wave_mode16 == 4'd15);
  assign top16 = (wave_mode16 == 4'd15 || wave_mode16 == 4'd4) ? compare_value_a16_q : `TPC_TOP16_FULL;
  assign at_top16 = (count16_q == top16);
  assign ma16 = (count16_q == compare_value_a16_q) && !(fast16 && out_mode_a16[1] && at_top16);
  assign mb16 = (count16_q == compare_value_b16_q) && !(fast16 && out_mode_b16[1] && at_top16);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count16_q           <= 16'h0000;
      compare_value_a16_q <= 16'h0000;
      compare_value_b16_q <= 16'h0000;
    end else if (tick) begin
      count16_q <= at_top16 ? 16'h0000 : count16_q + 16'd1;
      if (!fast16 || at_top16) begin
        compare_value_a16_q <= cmpa16_buf_q;
        compare_value_b16_q <= cmpb16_buf_q;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_out_a16_q <= 1'b0;
      compare_out_b16_q <= 1'b0;
    end else if (tick) begin
      if (fast16) begin
        if (out_mode_a16 == 2'b01 && ma16)
          compare_out_a16_q <= ~compare_out_a16_q;
        else if (out_mode_a16[1] && ma16)
          compare_out_a16_q <= out_mode_a16[0];
        else if (out_mode_a16[1] && at_top16)
          compare_out_a16_q <= ~out_mode_a16[0];
        if (out_mode_b16[1] && mb16)
          compare_out_b16_q <= out_mode_b16[0];
        else if (out_mode_b16[1] && at_top16)
          compare_out_b16_q <= ~out_mode_b16[0];
      end else begin
        if (ma16 && out_mode_a16 == 2'b01)
          compare_out_a16_q <= ~compare_out_a16_q;
        else if (ma16 && out_mode_a16[1])
          compare_out_a16_q <= out_mode_a16[0];
        if (mb16 && out_mode_b16 == 2'b01)
          compare_out_b16_q <= ~compare_out_b16_q;
        else if (mb16 && out_mode_b16[1])
          compare_out_b16_q <= out_mode_b16[0];
      end
    end
  end

  // pin drive
  logic conn_a8;
  logic conn_b8;
  logic conn_a16;
  logic conn_b16;
  assign conn_a8  = (out_mode_a8_q != 2'b00) && !(out_mode_a8_q == 2'b01 && !wave_mode_sel_q[2] && !(!dual8 && !fast8));
  assign conn_b8  = out_mode_b8_q[1] || (out_mode_b8_q == 2'b01 && !dual8 && !fast8);
  assign conn_a16 = (out_mode_a16 != 2'b00) && !(out_mode_a16 == 2'b01 && !fast16 && wave_mode16[0]);
  assign conn_b16 = out_mode_b16[1] || (out_mode_b16 == 2'b01 && !fast16);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_a8_o   <= 1'b0;
      pin_a8_oe  <= 1'b0;
      pin_b8_o   <= 1'b0;
      pin_b8_oe  <= 1'b0;
      pin_a16_o  <= 1'b0;
      pin_a16_oe <= 1'b0;
      pin_b16_o  <= 1'b0;
      pin_b16_oe <= 1'b0;
    end else begin
      pin_a8_o   <= compare_out_a8_q;
      pin_a8_oe  <= conn_a8 && dir_q[0];
      pin_b8_o   <= compare_out_b8_q;
      pin_b8_oe  <= conn_b8 && dir_q[1];
      pin_a16_o  <= compare_out_a16_q;
      pin_a16_oe <= conn_a16 && dir_q[2];
      pin_b16_o  <= compare_out_b16_q;
      pin_b16_oe <= conn_b16 && dir_q[3];
    end
  end

  // events and interrupt
  assign ev[`TPC_ST_OVF8]    = tick && dual8 && down8_q && timer8_count_q == 8'h01;
  assign ev[`TPC_ST_OVF16]   = tick && at_top16;
  assign ev[`TPC_ST_MATCHA8] = tick && ma8;
  assign ev[`TPC_ST_MATCHB8] = tick && mb8;
  assign ev[`TPC_ST_MATCHA16] = tick && ma16;
  assign ev[`TPC_ST_MATCHB16] = tick && mb16;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      status_q <= '0;
    else if (wr_q && addr_q == `TPC_OFF_STATUS)
      status_q <= (status_q & ~hwdata[`TPC_ST_W-1:0]) | ev;
    else
      status_q <= status_q | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(status_q & mask_q);
  end

  // ahb-lite slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 12'h000;
      bus_q  <= tpc_pkg::TPC_IDLE;
    end else if (hready) begin
      wr_q   <= hsel && htrans[1] && hwrite;
      rd_q   <= hsel && htrans[1] && !hwrite;
      addr_q <= {haddr[11:2], 2'b00};
      bus_q  <= (hsel && htrans[1]) ? tpc_pkg::TPC_DATA : tpc_pkg::TPC_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_mode_a8_q       <= 2'b00;
      out_mode_b8_q       <= 2'b00;
      wave_mode_sel_q     <= 3'd0;
      clk_sel8_q          <= 3'd0;
      cmpa8_buf_q         <= 8'h00;
      cmpb8_buf_q         <= 8'h00;
      timer16_control_a_q <= `TPC_CTRLA16_RST;
      ctrlb16_q           <= 3'd0;
      cmpa16_buf_q        <= 16'h0000;
      cmpb16_buf_q        <= 16'h0000;
      dir_q               <= 4'h0;
      mask_q              <= '0;
    end else if (wr_q) begin
      case (addr_q)
        `TPC_OFF_CTRL8: begin
          out_mode_a8_q   <= hwdata[7:6];
          out_mode_b8_q   <= hwdata[5:4];
          wave_mode_sel_q <= hwdata[2:0];
          clk_sel8_q      <= hwdata[10:8];
        end
        `TPC_OFF_CMPA8:   cmpa8_buf_q <= hwdata[7:0];
        `TPC_OFF_CMPB8:   cmpb8_buf_q <= hwdata[7:0];
        `TPC_OFF_CTRLA16: timer16_control_a_q <= hwdata[7:0] & `TPC_CTRLA16_WMASK;
        `TPC_OFF_CTRLB16: ctrlb16_q <= hwdata[2:0];
        `TPC_OFF_CMPA16:  cmpa16_buf_q <= hwdata[15:0];
        `TPC_OFF_CMPB16:  cmpb16_buf_q <= hwdata[15:0];
        `TPC_OFF_DIR:     dir_q <= hwdata[3:0];
        `TPC_OFF_MASK:    mask_q <= hwdata[`TPC_ST_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (haddr[11:0] & 12'hffc)
      `TPC_OFF_CTRL8:   rdata_d = {21'h0, clk_sel8_q, out_mode_a8_q, out_mode_b8_q, 1'b0, wave_mode_sel_q};
      `TPC_OFF_CMPA8:   rdata_d = {24'h0, cmpa8_buf_q};
      `TPC_OFF_CMPB8:   rdata_d = {24'h0, cmpb8_buf_q};
      `TPC_OFF_COUNT8:  rdata_d = {23'h0, down8_q, timer8_count_q};
      `TPC_OFF_CTRLA16: rdata_d = {24'h0, timer16_control_a_q};
      `TPC_OFF_CTRLB16: rdata_d = {29'h0, ctrlb16_q};
      `TPC_OFF_CMPA16:  rdata_d = {16'h0, cmpa16_buf_q};
      `TPC_OFF_CMPB16:  rdata_d = {16'h0, cmpb16_buf_q};
      `TPC_OFF_COUNT16: rdata_d = {16'h0, count16_q};
      `TPC_OFF_DIR:     rdata_d = {28'h0, dir_q};
      `TPC_OFF_STATUS:  rdata_d = {26'h0, status_q};
      `TPC_OFF_MASK:    rdata_d = {26'h0, mask_q};
      `TPC_OFF_PINS:    rdata_d = {28'h0, compare_out_b16_q, compare_out_a16_q, compare_out_b8_q, compare_out_a8_q};
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite)
        hrdata <= rdata_d;
    end
  end
endmodule

// [tb/tpc_top_properties.sv]
// Purpose: bus read and pin drive relations at the tpc_top ports
// Assumes: zero wait states, one word per register
// Notes: shadows ctrl a16, dir and mask from observed writes
`timescale 1ns/10ps
`include "tpc_defines.svh"
module tpc_top_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        irq,
  input wire logic        pin_a8_oe,
  input wire logic        pin_b8_oe,
  input wire logic        pin_a16_oe,
  input wire logic        pin_b16_oe
);
  logic        take;
  logic        wr_q;
  logic        rd_q;
  logic [11:0] adr_q;
  logic [7:0]  ca_q;
  logic [3:0]  dir_q;
  logic [5:0]  msk_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign take = hsel & htrans[1] & hready;
  // data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      adr_q <= 12'h000;
    end else begin
      wr_q  <= take & hwrite;
      rd_q  <= take & ~hwrite;
      adr_q <= haddr;
    end
  end
  // register shadows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ca_q  <= `TPC_CTRLA16_RST;
      dir_q <= 4'h0;
      msk_q <= 6'h00;
    end else if (wr_q) begin
      if (adr_q == `TPC_OFF_CTRLA16)
        ca_q <= hwdata[7:0] & `TPC_CTRLA16_WMASK;
      if (adr_q == `TPC_OFF_DIR)
        dir_q <= hwdata[3:0];
      if (adr_q == `TPC_OFF_MASK)
        msk_q <= hwdata[5:0];
    end
  end
  sequence s_rd(logic [11:0] a);
    rd_q && adr_q == a;
  endsequence
  sequence s_nomask;
    msk_q == 6'h00 ##1 msk_q == 6'h00;
  endsequence
  AST_CA_READ: assert property (s_rd(`TPC_OFF_CTRLA16) |-> hrdata == {24'h0, ca_q})
    else $error("ctrl a16 read back wrong");
  AST_UNMAP_READ: assert property (rd_q && adr_q > `TPC_OFF_PINS |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_OE_A8: assert property (pin_a8_oe |-> dir_q[0] || $past(dir_q[0]))
    else $error("pin a8 driven without direction");
  AST_OE_B8: assert property (pin_b8_oe |-> dir_q[1] || $past(dir_q[1]))
    else $error("pin b8 driven without direction");
  AST_OE_A16: assert property (pin_a16_oe |-> (dir_q[2] && ca_q[7:6] != 2'b00) ||
    ($past(dir_q[2]) && $past(ca_q[7:6]) != 2'b00)) else $error("pin a16 driven while off");
  AST_OE_B16: assert property (pin_b16_oe |-> (dir_q[3] && ca_q[5:4] != 2'b00) ||
    ($past(dir_q[3]) && $past(ca_q[5:4]) != 2'b00)) else $error("pin b16 driven while off");
  AST_IRQ_MASK: assert property (s_nomask |-> !irq)
    else $error("irq high with all masked");
endmodule
bind tpc_top tpc_top_properties i_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .irq, .pin_a8_oe, .pin_b8_oe, .pin_a16_oe, .pin_b16_oe);

// [tb/tpc_load_model.sv]
// Purpose: load on one compare output pin
// Assumes: a pull-down holds the pin low while undriven
// Notes: reports the last high and low widths in hclk cycles
`timescale 1ns/10ps
module tpc_load_model (
  input  wire logic        hclk,
  input  wire logic        pin_o,
  input  wire logic        pin_oe,
  output logic      [15:0] hi_len,
  output logic      [15:0] lo_len
);
  logic        lvl;
  logic        prv = 1'b0;
  logic [15:0] run = 16'h0;
  // level seen at the pad
  assign lvl = pin_oe & pin_o;
  initial hi_len = 16'h0;
  initial lo_len = 16'h0;
  always @(posedge hclk) begin
    prv <= lvl;
    run <= (lvl != prv) ? 16'h1 : run + 16'h1;
    if (lvl != prv && prv)
      hi_len <= run;
    if (lvl != prv && !prv)
      lo_len <= run;
  end
endmodule

// [tb/timer_pwm_compare_output_tb.sv]
// Purpose: register and waveform tests for tpc_top
// Assumes: zero wait ahb-lite slave, hclk at 10 MHz
// Notes: four load models measure pin widths
`timescale 1ns/10ps
`include "tpc_defines.svh"
module timer_pwm_compare_output_tb;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [11:0] haddr   = 12'h000;
  logic [1:0]  htrans  = 2'b00;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [3:0]  po;
  logic [3:0]  oe;
  logic [15:0] hi [4];
  logic [15:0] lo [4];
  logic [8:0]  obs;
  int          failures    = 0;
  int          checks_done = 0;
  localparam logic [11:0] C8 [6] = '{12'h181, 12'h1c1, 12'h281, 12'h125, 12'h145, 12'h147};
  localparam logic [7:0]  CA [6] = '{8'h80, 8'h80, 8'h80, 8'h40, 8'h40, 8'h40};
  localparam int          CH [6] = '{0, 0, 0, 1, 0, 0};
  localparam logic [31:0] EW [6] = '{32'h010000fe, 32'h00fe0100, 32'h080007f0, 32'h00200060, 32'h00800080,
                                     32'h00410041};
  always #50 hclk = ~hclk;
  assign hready = hreadyout;
  // observed outputs: oe 3:0, pin levels 7:4, irq 8
  assign obs    = {irq, po, oe};
  tpc_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .irq, .pin_a8_o(po[0]), .pin_a8_oe(oe[0]), .pin_b8_o(po[1]), .pin_b8_oe(oe[1]),
    .pin_a16_o(po[2]), .pin_a16_oe(oe[2]), .pin_b16_o(po[3]), .pin_b16_oe(oe[3]));
  for (genvar g = 0; g < 4; g++) begin : g_load
    tpc_load_model i_load (.hclk, .pin_o(po[g]), .pin_oe(oe[g]), .hi_len(hi[g]), .lo_len(lo[g]));
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic pin_is(input int s, input logic e);
    repeat (3) @(posedge hclk);
    chk({31'h0, obs[s]}, {31'h0, e});
  endtask
  task automatic meas(input int ch, input int cyc, input logic [31:0] e);
    repeat (cyc) @(posedge hclk);
    chk({hi[ch], lo[ch]}, e);
  endtask
  task automatic cfg16(input logic [31:0] b, input logic [31:0] a, input logic [31:0] cb);
    // ticks stop while modes change, so count16 never runs past top
    wr(`TPC_OFF_CTRL8, 32'h0);
    wr(`TPC_OFF_CMPB16, cb);
    wr(`TPC_OFF_CTRLB16, b);
    wr(`TPC_OFF_CTRLA16, a);
    wr(`TPC_OFF_CTRL8, 32'h100);
    repeat (1000) @(posedge hclk);
  endtask
  initial begin
    repeat (60000) @(posedge hclk);
    failures++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`TPC_OFF_CTRLA16, 32'h0);
    rd(12'h040, 32'h0);
    wr(`TPC_OFF_CTRLA16, 32'hffffffff);
    rd(`TPC_OFF_CTRLA16, 32'h000000f3);
    wr(`TPC_OFF_CTRLA16, 32'h0);
    $display("test registers done");
    wr(`TPC_OFF_DIR, 32'hf);
    wr(`TPC_OFF_CMPA16, 32'h63);
    cfg16(32'h1, 32'h40, 32'h0);
    meas(2, 0, 32'h00640064);
    pin_is(2, 1'b1);
    cfg16(32'h1, 32'hc0, 32'h0);
    pin_is(6, 1'b1);
    cfg16(32'h1, 32'h80, 32'h0);
    pin_is(6, 1'b0);
    cfg16(32'h3, 32'h63, 32'h1d);
    meas(2, 0, 32'h00640064);
    meas(3, 0, 32'h001e0046);
    cfg16(32'h3, 32'h73, 32'h1d);
    meas(3, 0, 32'h0046001e);
    cfg16(32'h3, 32'h23, 32'h63);
    pin_is(7, 1'b1);
    cfg16(32'h3, 32'h53, 32'h1d);
    pin_is(3, 1'b0);
    cfg16(32'h1, 32'h41, 32'h1d);
    pin_is(2, 1'b0);
    $display("test compare16 done");
    for (int i = 0; i < 6; i++) begin
      int n;
      n = 4 * (EW[i][31:16] + EW[i][15:0]) + 600;
      wr(`TPC_OFF_CTRL8, 32'h0);
      wr(`TPC_OFF_COUNT8, 32'h0);
      wr(`TPC_OFF_CMPA8, {24'h0, CA[i]});
      wr(`TPC_OFF_CMPB8, 32'h10);
      wr(`TPC_OFF_CTRL8, {20'h0, C8[i]});
      meas(CH[i], n, EW[i]);
    end
    pin_is(0, 1'b1);
    wr(`TPC_OFF_DIR, 32'h0);
    pin_is(0, 1'b0);
    wr(`TPC_OFF_DIR, 32'hf);
    $display("test dual slope done");
    wr(`TPC_OFF_MASK, 32'h1);
    pin_is(8, 1'b1);
    repeat (300) @(posedge hclk);
    pin_is(8, 1'b1);
    wr(`TPC_OFF_MASK, 32'h0);
    pin_is(8, 1'b0);
    wr(`TPC_OFF_CTRL8, 32'h0);
    wr(`TPC_OFF_MASK, 32'h1);
    pin_is(8, 1'b1);
    wr(`TPC_OFF_STATUS, 32'h3f);
    pin_is(8, 1'b0);
    $display("test overflow irq done");
    complete_run();
  end
endmodule
